// ===== hdl/frc_pkg.sv
// frc_pkg: opcodes, register field positions, reset values and timing for the
// flash register-access command logic; shared by design and bench.
package frc_pkg;
    localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
    localparam logic [7:0] OP_READ_STATUS_TWO = 8'h07;
    localparam logic [7:0] OP_READ_CONFIG     = 8'h35;
    localparam logic [7:0] OP_BANK_READ       = 8'h16;
    localparam logic [7:0] OP_BANK_WRITE      = 8'h17;
    localparam logic [7:0] OP_BANK_ACCESS     = 8'hB9;
    localparam logic [7:0] OP_WRITE_REGS      = 8'h01;
    localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;

    localparam int SR1_WIP_BIT   = 0;
    localparam int SR1_WEL_BIT   = 1;
    localparam int SR1_EERR_BIT  = 5;
    localparam int SR1_PERR_BIT  = 6;
    localparam int SR1_STATUS_WRITE_DISABLE_BIT  = 7;
    localparam int CR_QUAD_BIT   = 1;
    localparam int BANK_EXT_BIT  = 7;

    localparam logic [7:0] SR1_RESET  = 8'h00;
    localparam logic [7:0] SR2_RESET  = 8'h00;
    localparam logic [7:0] CR_RESET   = 8'h00;
    localparam logic [7:0] BANK_RESET = 8'h00;
    // bits written by the register update: status_write_disable, bp2..bp0 (wip/wel/errors are hardware)
    localparam logic [7:0] SR1_WRITE_MASK = 8'h9C;

    localparam int CLK_PERIOD_NS   = 8;
    localparam int WRR_TIME_NS     = 2000;
    localparam int WRR_CYCLES      = (WRR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_COUNT_W     = 5;
    localparam logic [4:0] BITS_OPCODE   = 5'h08;
    localparam logic [4:0] BITS_ONE_BYTE = 5'h10;
    localparam logic [4:0] BITS_TWO_BYTE = 5'h18;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
    } frc_spi_in_t;

    typedef struct packed {
        logic so;
        logic so_oe;
    } frc_spi_out_t;

    typedef struct packed {
        logic [7:0] status_one;
        logic [7:0] status_two;
        logic [7:0] config_reg;
        logic [7:0] bank_address;
    } frc_regs_t;
endpackage

// ===== hdl/frc_core.sv
// frc_core: serial flash register-access command interpreter.
// assumes sck, cs_n, si, wp_n arrive asynchronously and sck is well below i_sys_clk/4.
`timescale 1ns/1ps
module frc_core
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_reset,
    input  wire frc_pkg::frc_spi_in_t i_spi,
    input  wire logic                 i_wp_n,
    input  wire logic                 i_update_fail_program,
    input  wire logic                 i_update_fail_erase,
    input  wire logic [2:0]           i_array_sector,
    input  wire logic                 i_array_op_req,
    output frc_pkg::frc_spi_out_t     o_spi,
    output frc_pkg::frc_regs_t        o_regs,
    output logic                      o_array_op_ok,
    output logic                      o_hw_protected,
    output logic [1:0]                o_three_byte_high
);
    import frc_pkg::*;

    typedef enum logic [4:0]
    {
        ST_OPCODE = 5'b00001,
        ST_READ   = 5'b00010,
        ST_WRITE  = 5'b00100,
        ST_BANKWR = 5'b01000,
        ST_IGNORE = 5'b10000
    } frc_state_t;

    // two-flop synchronisers; stage one is read only by stage two
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic       sck_d;
    always_ff @(posedge i_sys_clk)
    begin
        sync_a <= {i_spi.sck, i_spi.cs_n, i_spi.si, i_wp_n};
        sync_b <= sync_a;
        sck_d  <= sync_b[3];
    end

    wire sck_s  = sync_b[3];
    wire cs_n_s = sync_b[2];
    wire si_s   = sync_b[1];
    wire wp_n_s = sync_b[0];
    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;

    logic [7:0]             status_one;
    logic [7:0]             status_two;
    logic [7:0]             config_reg;
    logic [7:0]             bank_address;
    logic [7:0]             shift_in;
    logic [7:0]             opcode;
    logic [7:0]             data_one;
    logic [7:0]             shift_out;
    logic [BIT_COUNT_W-1:0] bit_count;
    logic                   bank_open;
    logic                   cs_n_d;
    logic                   busy;
    logic [15:0]            busy_count;
    logic [7:0]             pend_sr1;
    logic [7:0]             pend_cr;
    logic                   pend_cr_en;
    logic                   hw_lock;
    logic                   so;
    logic                   so_oe;
    frc_state_t             state;
    frc_state_t             next_state;

    wire cs_rise = cs_n_s & ~cs_n_d;
    wire [7:0] next_shift = {shift_in[6:0], si_s};
    wire byte_done = sck_rise & (bit_count[2:0] == 3'h7);

    function automatic logic is_read_op(input logic [7:0] op);
        is_read_op = (op == OP_READ_STATUS_ONE) | (op == OP_READ_STATUS_TWO) |
                     (op == OP_READ_CONFIG) | (op == OP_BANK_READ);
    endfunction

    function automatic logic [7:0] read_source(input logic [7:0] op, input frc_regs_t r);
        case (op)
            OP_READ_STATUS_ONE: read_source = r.status_one;
            OP_READ_STATUS_TWO: read_source = r.status_two;
            OP_READ_CONFIG:     read_source = r.config_reg;
            default:            read_source = r.bank_address;
        endcase
    endfunction

    wire quad_on = config_reg[CR_QUAD_BIT];
    // quad mode repurposes the pin as data, so protection cannot hold
    wire hw_protect_now = status_one[SR1_STATUS_WRITE_DISABLE_BIT] & ~wp_n_s & ~quad_on;
    wire regs_writable = status_one[SR1_WEL_BIT] & ~hw_lock & ~busy;
    wire wrr_len_ok = (bit_count == BITS_ONE_BYTE) | (bit_count == BITS_TWO_BYTE);
    wire wrr_commit = cs_rise & (state == ST_WRITE) & wrr_len_ok & regs_writable;
    wire bank_commit = cs_rise & (state == ST_BANKWR) & (bit_count >= BITS_ONE_BYTE);
    wire write_enable_cmd_commit = cs_rise & (state == ST_IGNORE) & (bit_count == BITS_OPCODE) & (opcode == OP_WRITE_ENABLE);
    wire prefix_commit = cs_rise & (state == ST_IGNORE) & (bit_count == BITS_OPCODE) & (opcode == OP_BANK_ACCESS);
    wire done_pulse = busy & (busy_count == 16'h0001);

    frc_regs_t regs_now;
    assign regs_now = '{status_one, status_two, config_reg, bank_address};

    // opcode dispatch at the end of the first byte
    always_comb
    begin
        next_state = state;
        if (cs_n_s)
            next_state = ST_OPCODE;
        else if (state == ST_OPCODE && byte_done && bit_count == 5'h07)
        begin
            if (is_read_op(next_shift))
                next_state = ST_READ;
            else if (next_shift == OP_WRITE_REGS)
                next_state = bank_open ? ST_BANKWR : ST_WRITE;
            else if (next_shift == OP_BANK_WRITE)
                next_state = ST_BANKWR;
            else
                next_state = ST_IGNORE;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            state     <= ST_OPCODE;
            cs_n_d    <= 1'b1;
            bit_count <= '0;
            shift_in  <= 8'h00;
            opcode    <= 8'h00;
            data_one  <= 8'h00;
        end
        else
        begin
            state  <= next_state;
            cs_n_d <= cs_n_s;
            if (cs_n_s)
                bit_count <= '0;
            else if (sck_rise && bit_count != 5'h1F)
                bit_count <= bit_count + 5'h01;
            if (sck_rise && !cs_n_s)
                shift_in <= next_shift;
            if (byte_done && bit_count == 5'h07)
                opcode <= next_shift;
            if (byte_done && bit_count == 5'h0F)
                data_one <= next_shift;
        end
    end

    // read path: a fresh snapshot is taken at every byte boundary
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            shift_out <= 8'h00;
            so        <= 1'b0;
            so_oe     <= 1'b0;
        end
        else
        begin
            if (state == ST_READ && !cs_n_s)
            begin
                so_oe <= 1'b1;
                if (sck_fall)
                begin
                    so        <= shift_out[7];
                    shift_out <= {shift_out[6:0], 1'b0};
                end
                if (byte_done)
                    shift_out <= read_source(opcode, regs_now);
            end
            else
            begin
                so_oe <= 1'b0;
                if (byte_done && bit_count == 5'h07)
                    shift_out <= read_source(next_shift, regs_now);
            end
        end
    end

    // prefix opens bank access; any following select cycle other than another prefix closes it
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            bank_open <= 1'b0;
        else if (prefix_commit)
            bank_open <= 1'b1;
        else if (cs_rise)
            bank_open <= 1'b0;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            bank_address <= BANK_RESET;
        else if (bank_commit && state == ST_BANKWR && opcode == OP_BANK_WRITE)
            bank_address <= data_one;
        else if (bank_commit)
            bank_address <= {bank_address[7:2], data_one[1:0]};
    end

    // protection latches once reached; the pin going high or quad mode releases it
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            hw_lock <= 1'b0;
        else if (wp_n_s || quad_on)
            hw_lock <= 1'b0;
        else if (hw_protect_now)
            hw_lock <= 1'b1;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            busy       <= 1'b0;
            busy_count <= 16'h0000;
            pend_sr1   <= 8'h00;
            pend_cr    <= 8'h00;
            pend_cr_en <= 1'b0;
        end
        else if (wrr_commit)
        begin
            busy       <= 1'b1;
            busy_count <= 16'(WRR_CYCLES);
            pend_sr1   <= data_one;
            pend_cr    <= shift_in;
            pend_cr_en <= (bit_count == BITS_TWO_BYTE);
        end
        else if (busy)
        begin
            busy_count <= busy_count - 16'h0001;
            if (done_pulse)
                busy <= 1'b0;
        end
    end

    wire fail_any = i_update_fail_program | i_update_fail_erase;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            status_one <= SR1_RESET;
            status_two <= SR2_RESET;
            config_reg <= CR_RESET;
        end
        else
        begin
            status_one[SR1_WIP_BIT] <= busy & ~done_pulse | wrr_commit;
            if (done_pulse)
            begin
                status_one[SR1_WEL_BIT] <= 1'b0;
                if (!fail_any)
                begin
                    status_one[7:2] <= (pend_sr1[7:2] & SR1_WRITE_MASK[7:2]) |
                                       (status_one[7:2] & ~SR1_WRITE_MASK[7:2]);
                    if (pend_cr_en)
                        config_reg <= pend_cr;
                end
                if (i_update_fail_program)
                    status_one[SR1_PERR_BIT] <= 1'b1;
                if (i_update_fail_erase)
                    status_one[SR1_EERR_BIT] <= 1'b1;
            end
            else if (write_enable_cmd_commit && !busy)
                status_one[SR1_WEL_BIT] <= 1'b1;
        end
    end

    // block protect: code n locks the top n eighths, code 7 locks all
    wire [2:0] bp_code = status_one[4:2];
    wire       sector_locked = (bp_code == 3'h7) | ((bp_code != 3'h0) & (i_array_sector >= (3'h7 - bp_code + 3'h1)));
    assign o_array_op_ok = i_array_op_req & ~sector_locked & status_one[SR1_WEL_BIT] & ~busy;

    assign o_spi.so          = so;
    assign o_spi.so_oe       = so_oe;
    assign o_regs            = regs_now;
    assign o_hw_protected    = hw_lock;
    assign o_three_byte_high = bank_address[BANK_EXT_BIT] ? 2'b00 : bank_address[1:0];

    a_wel_needed: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        wrr_commit |-> $past(status_one[SR1_WEL_BIT]) || status_one[SR1_WEL_BIT])
        else $error("write accepted without latch");
    a_hw_lock_rejects: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        hw_lock && !busy |=> !status_one[SR1_WIP_BIT])
        else $error("write started under protection");
    a_wip_follows: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        wrr_commit |=> status_one[SR1_WIP_BIT] [*2])
        else $error("wip not raised");
    a_done_clears: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        done_pulse |=> !status_one[SR1_WIP_BIT] && !status_one[SR1_WEL_BIT])
        else $error("completion did not clear wip and latch");
    a_ext_kept: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        bank_commit && opcode == OP_WRITE_REGS |=> $stable(bank_address[7:2]))
        else $error("prefix write changed upper bank bits");
    a_bank_keeps_err: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        bank_commit |=> status_one[SR1_PERR_BIT] == $past(status_one[SR1_PERR_BIT]))
        else $error("bank write moved error flag");
    a_prefix_closes: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        cs_rise && !prefix_commit |=> !bank_open)
        else $error("bank access stayed open");
    a_lock_release: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        hw_lock && !wp_n_s && !quad_on |=> hw_lock)
        else $error("protection released without pin");
    a_oe_idle: assert property (@(posedge i_sys_clk) disable iff (i_reset) cs_n_s && cs_n_d |-> !so_oe)
        else $error("output enabled while deselected");
    c_wrr_done: cover property (@(posedge i_sys_clk) disable iff (i_reset) done_pulse);
    c_bank_prefix: cover property (@(posedge i_sys_clk) disable iff (i_reset)
        bank_commit && opcode == OP_WRITE_REGS);
    c_read_stream: cover property (@(posedge i_sys_clk) disable iff (i_reset)
        state == ST_READ && byte_done);
endmodule

// ===== tb/frc_host_model.sv
// frc_host_model: spi host sending mode-0 frames to the register logic.
// assumes i_sys_clk at 125 MHz; sck half period is 5 cycles (80 ns period).
`timescale 1ns/1ps
module frc_host_model
(
    input  wire logic            i_sys_clk,
    input  wire logic            i_so,
    output frc_pkg::frc_spi_in_t o_spi
);
    import frc_pkg::*;
    frc_spi_in_t spi = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
    assign o_spi = spi;

    // nw of -8 gives a bare select cycle with no clocks
    task automatic frame(input logic [7:0] op, input logic [15:0] wd, input int nw, input int nr,
                         output logic [15:0] rd);
        rd = '0;
        spi.cs_n <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        for (int i = 0; i < 8 + nw + nr; i++)
        begin
            // msb first, set while sck low, read just before sck rises
            spi.si <= (i < 8) ? op[7 - i] : (i < 8 + nw) ? wd[23 - i] : 1'b0;
            repeat (5) @(posedge i_sys_clk);
            if (i >= 8 + nw)
                rd = {rd[14:0], i_so};
            spi.sck <= 1'b1;
            repeat (5) @(posedge i_sys_clk);
            spi.sck <= 1'b0;
        end
        repeat (5) @(posedge i_sys_clk);
        spi.cs_n <= 1'b1;
        // released line must not keep its last level
        spi.si <= ~spi.si;
        repeat (10) @(posedge i_sys_clk);
    endtask
endmodule

// ===== tb/test_flash_register_access_cmds.sv
// test_flash_register_access_cmds: directed checks of the register commands.
// assumes frc_host_model as spi host and the update time of WRR_CYCLES.
`timescale 1ns/1ps
module test_flash_register_access_cmds;
    import frc_pkg::*;
    logic         sys_clk    = 1'b0;
    logic         reset      = 1'b1;
    logic         wp_n       = 1'b1;
    logic         fail_prog  = 1'b0;
    logic         fail_erase = 1'b0;
    logic [2:0]   sector     = 3'h0;
    logic         op_req     = 1'b0;
    frc_spi_in_t  spi_in;
    frc_spi_out_t spi_out;
    frc_regs_t    regs;
    logic         op_ok;
    logic         hw_prot;
    logic [1:0]   high_bits;
    logic [15:0]  rd;
    int           err_count  = 0;
    int           cmp_count  = 0;

    frc_core i_dut (.i_sys_clk(sys_clk), .i_reset(reset), .i_spi(spi_in), .i_wp_n(wp_n),
        .i_update_fail_program(fail_prog), .i_update_fail_erase(fail_erase),
        .i_array_sector(sector), .i_array_op_req(op_req), .o_spi(spi_out), .o_regs(regs),
        .o_array_op_ok(op_ok), .o_hw_protected(hw_prot), .o_three_byte_high(high_bits));
    frc_host_model i_host (.i_sys_clk(sys_clk), .i_so(spi_out.so), .o_spi(spi_in));

    initial
        forever #4 sys_clk = ~sys_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [15:0] wd, input int nw, input int nr);
        i_host.frame(op, wd, nw, nr, rd);
    endtask

    task automatic write_registers_cmd(input logic [15:0] wd, input int nw);
        cmd(OP_WRITE_ENABLE, 16'h0000, 0, 0);
        cmd(OP_WRITE_REGS, wd, nw, 0);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (regs.status_one[SR1_WIP_BIT] !== 1'b0 && n < 400)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk(16'(n < 400), 16'h0001);
        // registered flags that follow completion settle one edge later
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic t_reset();
        chk(regs.bank_address, BANK_RESET);
        chk(regs.status_one, SR1_RESET);
        cmd(OP_READ_STATUS_ONE, 16'h0000, 0, 16);
        chk(rd, {SR1_RESET, SR1_RESET});
        chk(spi_out.so_oe, 1'b0);
        cmd(OP_READ_STATUS_TWO, 16'h0000, 0, 16);
        chk(rd, {SR2_RESET, SR2_RESET});
        $display("test reset done");
    endtask

    task automatic t_write_status();
        cmd(OP_WRITE_REGS, 16'h0C00, 8, 0);
        chk(regs.status_one, 8'h00);
        cmd(OP_WRITE_ENABLE, 16'h0000, 0, 0);
        chk(regs.status_one[SR1_WEL_BIT], 1'b1);
        cmd(OP_WRITE_REGS, 16'h0C00, 8, 0);
        chk(regs.status_one[SR1_WIP_BIT], 1'b1);
        cmd(OP_READ_STATUS_ONE, 16'h0000, 0, 8);
        chk(rd[7:0], 8'h03);
        wait_idle();
        chk(regs.status_one, 8'h0C);
        $display("test write status done");
    endtask

    task automatic t_config();
        write_registers_cmd(16'h1C02, 12);
        chk(regs.status_one[7:2], 6'h03);
        write_registers_cmd(16'h0C02, 16);
        wait_idle();
        chk(regs.config_reg, 8'h02);
        cmd(OP_READ_CONFIG, 16'h0000, 0, 16);
        chk(rd, 16'h0202);
        // quad set: only the sixteen-bit form from here
        write_registers_cmd(16'h8C02, 16);
        wait_idle();
        wp_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(hw_prot, 1'b0);
        write_registers_cmd(16'h0C00, 16);
        wait_idle();
        chk({regs.status_one, regs.config_reg}, 16'h0C00);
        wp_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        $display("test config done");
    endtask

    task automatic t_protect();
        wp_n <= 1'b0;
        write_registers_cmd(16'h8C00, 8);
        wait_idle();
        chk(regs.status_one, 8'h8C);
        chk(hw_prot, 1'b1);
        write_registers_cmd(16'h0C00, 8);
        wait_idle();
        chk(regs.status_one[7:2], 6'h23);
        wp_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk(hw_prot, 1'b0);
        write_registers_cmd(16'h0C00, 8);
        wait_idle();
        chk(regs.status_one, 8'h0C);
        $display("test protect done");
    endtask

    task automatic t_bank();
        cmd(OP_BANK_WRITE, 16'h8100, 8, 0);
        chk(regs.bank_address, 8'h81);
        chk(high_bits, 2'h0);
        cmd(OP_BANK_READ, 16'h0000, 0, 16);
        chk(rd, 16'h8181);
        cmd(OP_BANK_WRITE, 16'h0200, 8, 0);
        chk(high_bits, 2'h2);
        chk(regs.status_one, 8'h0C);
        cmd(OP_BANK_WRITE, 16'h8000, 8, 0);
        // prefix makes the next write-registers frame set only the low two bank bits
        cmd(OP_BANK_ACCESS, 16'h0000, 0, 0);
        cmd(OP_WRITE_REGS, 16'hFDFF, 16, 0);
        chk(regs.bank_address, 8'h81);
        chk(regs.status_one, 8'h0C);
        cmd(OP_WRITE_REGS, 16'h0200, 8, 0);
        chk(regs.bank_address, 8'h81);
        cmd(OP_BANK_ACCESS, 16'h0000, 0, 0);
        cmd(OP_BANK_READ, 16'h0000, 0, 8);
        chk(rd[7:0], 8'h81);
        cmd(OP_BANK_ACCESS, 16'h0000, 0, 0);
        cmd(8'h00, 16'h0000, -8, 0);
        cmd(OP_WRITE_REGS, 16'h0200, 8, 0);
        chk(regs.bank_address, 8'h81);
        $display("test bank done");
    endtask

    task automatic t_array();
        cmd(OP_WRITE_ENABLE, 16'h0000, 0, 0);
        op_req <= 1'b1;
        for (int s = 0; s < 8; s++)
        begin
            sector <= 3'(s);
            repeat (2) @(posedge sys_clk);
            chk(op_ok, 16'(s < 5));
        end
        op_req <= 1'b0;
        $display("test array done");
    endtask

    task automatic t_fail();
        fail_prog <= 1'b1;
        write_registers_cmd(16'h1C00, 8);
        // flags do not hold the device busy; wait the fixed update time plus margin
        repeat (WRR_CYCLES + 20) @(posedge sys_clk);
        chk(regs.status_one[SR1_PERR_BIT], 1'b1);
        chk(regs.status_one[4:2], 3'h3);
        fail_prog <= 1'b0;
        fail_erase <= 1'b1;
        write_registers_cmd(16'h1C00, 8);
        repeat (WRR_CYCLES + 20) @(posedge sys_clk);
        chk(regs.status_one[SR1_EERR_BIT], 1'b1);
        chk(regs.status_one[4:2], 3'h3);
        fail_erase <= 1'b0;
        $display("test fail done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (5) @(posedge sys_clk);
        t_reset();
        t_write_status();
        t_config();
        t_protect();
        t_bank();
        t_array();
        t_fail();
        summarize();
    end

    initial
    begin
        #400_000;
        err_count++;
        summarize();
    end
endmodule
